// ===== sfr_check_pkg.sv
// Purpose: Shared constants and types for the register access checker.
// Assumes: Register addresses are Avalon word indices, eight bits wide.
// Notes: Group ranges and own register offsets are fixed at build time.
package sfr_check_pkg;

    // CPU mode codes as presented on the mode sideband
    localparam logic [2:0] MODE_BOOT = 3'h0;
    localparam logic [2:0] MODE_TEST = 3'h1;
    localparam logic [2:0] MODE_FIRMWARE = 3'h2;
    localparam logic [2:0] MODE_SYSTEM = 3'h3;
    localparam logic [2:0] MODE_USER = 3'h4;

    // Register group ranges, inclusive word indices
    localparam logic [7:0] GEN_CPU_LO = 8'h00;
    localparam logic [7:0] GEN_CPU_HI = 8'h0f;
    localparam logic [7:0] DUP_CPU_LO = 8'h10;
    localparam logic [7:0] DUP_CPU_HI = 8'h17;
    localparam logic [7:0] SEG_CFG_LO = 8'h18;
    localparam logic [7:0] SEG_CFG_HI = 8'h1f;
    localparam logic [7:0] SYS_MGMT_LO = 8'h20;
    localparam logic [7:0] SYS_MGMT_HI = 8'h2f;
    localparam logic [7:0] FW_CFG_LO = 8'h30;
    localparam logic [7:0] FW_CFG_HI = 8'h37;
    localparam logic [7:0] FW_OS_LO = 8'h38;
    localparam logic [7:0] FW_OS_HI = 8'h3f;
    localparam logic [7:0] TEST_LO = 8'h40;
    localparam logic [7:0] TEST_HI = 8'h4f;
    localparam logic [7:0] HW_LO = 8'h80;
    localparam logic [7:0] HW_HI = 8'h8f;

    // Registers with fixed extra restrictions
    localparam logic [7:0] SEG_TABLE_BASE_ADDR = 8'h18;
    localparam logic [7:0] CPU_CONTROL_STATUS_ADDR = 8'h20;
    localparam logic [7:0] SEG_TABLE_SHADOW_ADDR = 8'h21;
    localparam logic [7:0] VIOLATION_STATUS_ADDR = 8'h22;
    localparam logic [7:0] FW_CTRL_LOW_ADDR = 8'h30;
    localparam logic [7:0] FW_CTRL_HIGH_ADDR = 8'h31;
    localparam logic [7:0] CLOCK_SELECT_ADDR = 8'h80;
    localparam logic [7:0] RANDOM_RESULT_ADDR = 8'h81;
    localparam logic [7:0] CIPHER_KEY_LO = 8'h88;
    localparam logic [7:0] CIPHER_KEY_HI = 8'h8b;

    // Restrictive reset values, fixed in hardware
    localparam logic [31:0] SEG_TABLE_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] FW_CTRL_RST = 16'h0000;

    // Segment table layout: one 32-bit word per segment
    localparam int SEG_COUNT = 64;
    localparam int SEG_IDX_W = 6;
    localparam int SEG_ENTRY_SHIFT = 2;
    localparam int PERM_LSB = 0;
    localparam int PERM_W = 3;
    localparam int PERIPH_LSB = 16;
    localparam int PERIPH_W = 16;

    // Request sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_DECIDE, ST_FWD, ST_CAP, ST_DONE
    } ctl_state_e;

endpackage

// ===== sfr_mode_access_checker.sv
// Purpose: Grants or denies every CPU register access by CPU mode.
// Assumes: CPU reaches registers over Avalon-MM; sidebands on same clock.
// Notes: Denied accesses raise a one-cycle exception and read as zero.
`timescale 1ns/1ps
module sfr_mode_access_checker
    import sfr_check_pkg::*;
(
    input wire logic core_clk_in,                // System clock
    input wire logic sys_rst_in,                 // Synchronous reset
    input wire logic [7:0] avs_address_in,       // Register word index
    input wire logic avs_read_in,                // Read request
    input wire logic avs_write_in,               // Write request
    input wire logic [31:0] avs_writedata_in,    // Write data
    input wire logic [3:0] avs_byteenable_in,    // Write byte lanes
    output logic [31:0] avs_readdata_out,        // Read data, zero if denied
    output logic avs_waitrequest_out,            // Low for one answer cycle
    input wire logic [2:0] cpu_mode_in,          // Current CPU mode
    input wire logic [SEG_IDX_W-1:0] seg_index_in, // Segment being fetched from
    input wire logic copy_src_in,                // Access issued by copy engine
    input wire logic copy_start_in,              // Copy engine start pulse
    input wire logic copy_done_in,               // Copy engine finish pulse
    output logic seg_rd_out,                     // Segment entry fetch request
    output logic [31:0] seg_addr_out,            // Byte address of the entry
    input wire logic seg_rd_valid_in,            // Entry data valid
    input wire logic [31:0] seg_rdata_in,        // Entry data
    output logic sfr_rd_out,                     // Forwarded read strobe
    output logic sfr_wr_out,                     // Forwarded write strobe
    output logic [7:0] sfr_addr_out,             // Forwarded address
    output logic [31:0] sfr_wdata_out,           // Forwarded write data
    output logic [3:0] sfr_be_out,               // Forwarded byte lanes
    input wire logic [31:0] sfr_rdata_in,        // Data, cycle after strobe
    output logic exception_out                   // Denied access pulse
);

    ctl_state_e state;            // Request sequencer
    logic [7:0] req_addr;         // Captured address
    logic req_wr;                 // Captured direction
    logic [31:0] req_wdata;       // Captured write data
    logic [3:0] req_be;           // Captured byte lanes
    logic [2:0] req_mode;         // Mode that the access is judged by
    logic [31:0] seg_entry;       // Fetched entry, zero when none
    logic [31:0] rdata_hold;      // Internal or zeroed read result
    logic ext_read;               // Read data comes from outside
    logic [2:0] copy_mode;        // Mode frozen at copy start
    logic copy_active;            // Copy engine running
    logic [31:0] seg_table_base;  // Segment table byte address
    logic [31:0] seg_table_shadow; // Write-only copy of the base
    logic [15:0] fw_ctrl_low;     // Firmware peripheral read rights
    logic [15:0] fw_ctrl_high;    // Firmware peripheral write rights
    logic [7:0] viol_count;       // Denied access counter, saturating
    logic [7:0] viol_addr;        // Address of the last denial
    logic [2:0] viol_mode;        // Mode of the last denial
    logic viol_wr;                // Direction of the last denial
    logic allow;                  // Decision for the captured access
    logic internal;               // Register is held in this block
    logic [2:0] eff_mode;         // Mode of the incoming request
    logic need_fetch;             // Incoming request needs a table entry

    // Group membership of the captured address
    logic in_gen, in_dup, in_seg, in_sys, in_fwcfg, in_fwos, in_test, in_hw;
    logic [3:0] periph;           // Peripheral slot inside the hw group
    assign in_gen = (req_addr >= GEN_CPU_LO) && (req_addr <= GEN_CPU_HI);
    assign in_dup = (req_addr >= DUP_CPU_LO) && (req_addr <= DUP_CPU_HI);
    assign in_seg = (req_addr >= SEG_CFG_LO) && (req_addr <= SEG_CFG_HI);
    assign in_sys = (req_addr >= SYS_MGMT_LO) && (req_addr <= SYS_MGMT_HI);
    assign in_fwcfg = (req_addr >= FW_CFG_LO) && (req_addr <= FW_CFG_HI);
    assign in_fwos = (req_addr >= FW_OS_LO) && (req_addr <= FW_OS_HI);
    assign in_test = (req_addr >= TEST_LO) && (req_addr <= TEST_HI);
    assign in_hw = (req_addr >= HW_LO) && (req_addr <= HW_HI);
    assign periph = req_addr[3:0];

    // The copy engine is judged by its frozen mode, not the live one
    assign eff_mode = (copy_src_in && copy_active) ? copy_mode
                                                  : cpu_mode_in;
    // Only user peripheral accesses with a live table need an entry
    assign need_fetch = (eff_mode == MODE_USER)
        && (avs_address_in >= HW_LO) && (avs_address_in <= HW_HI)
        && (seg_table_base != SEG_TABLE_BASE_RST);

    assign internal = (req_addr == SEG_TABLE_BASE_ADDR)
        || (req_addr == SEG_TABLE_SHADOW_ADDR)
        || (req_addr == VIOLATION_STATUS_ADDR)
        || (req_addr == FW_CTRL_LOW_ADDR)
        || (req_addr == FW_CTRL_HIGH_ADDR);

    // Access decision; fixed restrictions override the mode grants
    always_comb begin
        allow = 1'b0;
        unique case (req_mode)
            MODE_BOOT: begin
                // Unmapped holes stay denied in every mode
                allow = in_gen || in_sys || in_fwcfg || in_fwos
                    || in_hw;
            end
            MODE_TEST: begin
                allow = in_gen || in_seg || in_sys || in_fwcfg || in_fwos
                    || in_test || in_hw;
            end
            MODE_FIRMWARE: begin
                allow = in_gen
                    || (in_fwcfg && !req_wr)
                    || in_fwos
                    || (in_hw && !req_wr && fw_ctrl_low[periph])
                    || (in_hw && req_wr && fw_ctrl_high[periph])
                    || (req_addr == CLOCK_SELECT_ADDR && !req_wr)
                    || (req_addr == CPU_CONTROL_STATUS_ADDR
                        && !req_wr);
            end
            MODE_SYSTEM: begin
                allow = in_gen || in_dup || in_seg || in_sys || in_fwcfg
                    || in_hw;
            end
            MODE_USER: begin
                // Entry with no memory rights marks a disabled segment
                allow = in_gen || in_dup
                    || (in_hw && (seg_entry[PERM_LSB +: PERM_W] != 3'h0)
                        && seg_entry[PERIPH_LSB + periph])
                    || (req_addr == CPU_CONTROL_STATUS_ADDR
                        && !req_wr);
            end
            default: allow = 1'b0;
        endcase
        // Segment config is system only; duplicated CPU never in low modes
        if (in_seg && req_mode != MODE_SYSTEM) begin
            allow = 1'b0;
        end
        if (in_dup && req_mode != MODE_SYSTEM && req_mode != MODE_USER) begin
            allow = 1'b0;
        end
        if (req_addr == SEG_TABLE_SHADOW_ADDR && !req_wr) begin
            allow = 1'b0;
        end
        if (req_addr == RANDOM_RESULT_ADDR && req_wr) begin
            allow = 1'b0;
        end
        if (req_addr >= CIPHER_KEY_LO && req_addr <= CIPHER_KEY_HI
            && !req_wr) begin
            allow = 1'b0;
        end
    end

    // Request sequencer: one request in flight at a time
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        state <= need_fetch ? ST_FETCH : ST_DECIDE;
                    end
                end
                ST_FETCH: begin
                    // Waits on memory; a stuck memory stalls the CPU here
                    if (seg_rd_valid_in) begin
                        state <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    state <= (allow && !internal) ? ST_FWD : ST_CAP;
                end
                ST_FWD: state <= ST_CAP;
                ST_CAP: state <= ST_DONE;
                ST_DONE: state <= ST_IDLE;
            endcase
        end
    end

    // Request capture; the entry starts at zero so no fetch means no rights
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            req_addr <= 8'h00;
            req_wr <= 1'b0;
            req_wdata <= 32'h0000_0000;
            req_be <= 4'h0;
            req_mode <= MODE_BOOT;
            seg_entry <= 32'h0000_0000;
        end else if (state == ST_IDLE && (avs_read_in || avs_write_in)) begin
            req_addr <= avs_address_in;
            req_wr <= avs_write_in;
            req_wdata <= avs_writedata_in;
            req_be <= avs_byteenable_in;
            req_mode <= eff_mode;
            seg_entry <= 32'h0000_0000;
        end else if (state == ST_FETCH && seg_rd_valid_in) begin
            seg_entry <= seg_rdata_in;
        end
    end

    // Entry fetch from ordinary memory, one word per segment
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            seg_rd_out <= 1'b0;
            seg_addr_out <= 32'h0000_0000;
        end else if (state == ST_IDLE && (avs_read_in || avs_write_in)
            && need_fetch) begin
            seg_rd_out <= 1'b1;
            seg_addr_out <= seg_table_base
                + {24'h000000, seg_index_in, 2'b00};
        end else if (state == ST_FETCH && seg_rd_valid_in) begin
            seg_rd_out <= 1'b0;
        end
    end

    // Copy engine mode latch, frozen from start to finish
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            copy_active <= 1'b0;
            copy_mode <= MODE_BOOT;
        end else if (copy_start_in) begin
            copy_active <= 1'b1;
            copy_mode <= cpu_mode_in;
        end else if (copy_done_in) begin
            copy_active <= 1'b0;
        end
    end

    // Registers held here; constants only at reset, no preload path
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            seg_table_base <= SEG_TABLE_BASE_RST;
            seg_table_shadow <= SEG_TABLE_BASE_RST;
            fw_ctrl_low <= FW_CTRL_RST;
            fw_ctrl_high <= FW_CTRL_RST;
        end else if (state == ST_DECIDE && allow && req_wr) begin
            // Writes reach here only when granted
            for (int b = 0; b < 4; b++) begin
                if (req_be[b] && req_addr == SEG_TABLE_BASE_ADDR) begin
                    seg_table_base[8*b +: 8] <= req_wdata[8*b +: 8];
                    seg_table_shadow[8*b +: 8] <= req_wdata[8*b +: 8];
                end
            end
            for (int b = 0; b < 2; b++) begin
                if (req_be[b] && req_addr == FW_CTRL_LOW_ADDR) begin
                    fw_ctrl_low[8*b +: 8] <= req_wdata[8*b +: 8];
                end
                if (req_be[b] && req_addr == FW_CTRL_HIGH_ADDR) begin
                    fw_ctrl_high[8*b +: 8] <= req_wdata[8*b +: 8];
                end
            end
        end
    end

    // Violation record for software diagnosis
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            viol_count <= 8'h00;
            viol_addr <= 8'h00;
            viol_mode <= MODE_BOOT;
            viol_wr <= 1'b0;
        end else if (state == ST_DECIDE && !allow) begin
            viol_count <= (viol_count == 8'hff) ? viol_count
                                                : viol_count + 8'h01;
            viol_addr <= req_addr;
            viol_mode <= req_mode;
            viol_wr <= req_wr;
        end
    end

    // Forwarding and exception; a denial never strobes the register
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sfr_rd_out <= 1'b0;
            sfr_wr_out <= 1'b0;
            sfr_addr_out <= 8'h00;
            sfr_wdata_out <= 32'h0000_0000;
            sfr_be_out <= 4'h0;
            exception_out <= 1'b0;
            ext_read <= 1'b0;
        end else begin
            sfr_rd_out <= 1'b0;
            sfr_wr_out <= 1'b0;
            exception_out <= 1'b0;
            if (state == ST_IDLE) begin
                ext_read <= 1'b0;
            end
            if (state == ST_DECIDE) begin
                if (allow && !internal) begin
                    sfr_rd_out <= !req_wr;
                    sfr_wr_out <= req_wr;
                    sfr_addr_out <= req_addr;
                    sfr_wdata_out <= req_wdata;
                    sfr_be_out <= req_be;
                    ext_read <= !req_wr;
                end else if (!allow) begin
                    exception_out <= 1'b1;
                end
            end
        end
    end

    // Internal read result, zero for denials and writes
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            rdata_hold <= 32'h0000_0000;
        end else if (state == ST_DECIDE) begin
            rdata_hold <= 32'h0000_0000;
            if (allow && !req_wr) begin
                unique case (req_addr)
                    SEG_TABLE_BASE_ADDR: rdata_hold <= seg_table_base;
                    FW_CTRL_LOW_ADDR: rdata_hold <= {16'h0000, fw_ctrl_low};
                    FW_CTRL_HIGH_ADDR: rdata_hold <= {16'h0000, fw_ctrl_high};
                    VIOLATION_STATUS_ADDR: rdata_hold <= {12'h000, viol_count,
                        viol_wr, viol_mode, viol_addr};
                    default: rdata_hold <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Bus answer: waitrequest drops for exactly the DONE cycle
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else if (state == ST_CAP) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= ext_read ? sfr_rdata_in : rdata_hold;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    deny_raises_exc_a: assert property (
        (state == ST_DECIDE && !allow) |=> exception_out)
        else $error("denied access raised no exception");
    deny_quiet_bus_a: assert property (
        exception_out |=> (avs_readdata_out == 32'h0 && !avs_waitrequest_out
            && !sfr_rd_out && !sfr_wr_out))
        else $error("denied access leaked data or strobe");
    seg_sys_only_a: assert property (
        (state == ST_DECIDE && in_seg && req_mode != MODE_SYSTEM) |-> !allow)
        else $error("segment config granted outside system mode");
    dup_low_deny_a: assert property (
        (state == ST_DECIDE && in_dup && (req_mode == MODE_BOOT
            || req_mode == MODE_TEST || req_mode == MODE_FIRMWARE))
        |=> exception_out)
        else $error("duplicated register granted in low mode");
    shadow_no_read_a: assert property (
        (state == ST_DECIDE && req_addr == SEG_TABLE_SHADOW_ADDR && !req_wr)
        |=> exception_out ##2 (avs_readdata_out == 32'h0))
        else $error("shadow register was readable");
    rng_no_write_a: assert property (
        (state == ST_DECIDE && req_addr == RANDOM_RESULT_ADDR && req_wr)
        |=> !sfr_wr_out && exception_out)
        else $error("random result register was written");
    key_no_read_a: assert property (
        (state == ST_DECIDE && !req_wr && req_addr >= CIPHER_KEY_LO
            && req_addr <= CIPHER_KEY_HI) |=> !sfr_rd_out)
        else $error("cipher key register was read");
    gen_cpu_open_a: assert property (
        (state == ST_DECIDE && in_gen) |=> !exception_out)
        else $error("plain CPU register denied");
    base_reset_zero_a: assert property (
        $past(sys_rst_in) |-> (seg_table_base == SEG_TABLE_BASE_RST))
        else $error("segment table base not cleared by reset");
    copy_mode_hold_a: assert property (
        (copy_active && !copy_start_in) |=> $stable(copy_mode))
        else $error("copy mode changed during a copy");
    answer_bound_a: assert property (
        (state == ST_DECIDE) |-> ##[2:3] !avs_waitrequest_out)
        else $error("decided access not answered in time");

    user_fetch_c: cover property (
        state == ST_FETCH ##1 seg_rd_valid_in ##1 state == ST_DECIDE);
    fw_hw_grant_c: cover property (
        state == ST_DECIDE && req_mode == MODE_FIRMWARE && in_hw && allow);
    deny_c: cover property (exception_out);
    relocate_c: cover property (
        state == ST_DECIDE && allow && req_wr
        && req_addr == SEG_TABLE_BASE_ADDR);

endmodule

// ===== far_side_model.sv
// Purpose: Far-side memory and peripheral model for the access checker.
// Assumes: Table sits at 0x100; segment 1 opens slot 1 only, others empty.
// Notes: Idle data lines toggle so stale values can never pass a check.
`timescale 1ns/1ps
module far_side_model (
    input wire logic clk_in,
    input wire logic seg_rd_in,
    input wire logic [31:0] seg_addr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_addr_in,
    output logic seg_valid_out,
    output logic [31:0] seg_data_out,
    output logic [31:0] sfr_data_out
);
    logic [1:0] wait_cnt = 2'h0; // Slow memory, two wait cycles
    initial begin
        seg_valid_out = 1'b0;
        seg_data_out = 32'h0;
        sfr_data_out = 32'h0;
    end
    // Entry fetch from plain memory, answered late on purpose
    always @(posedge clk_in) begin
        seg_valid_out <= seg_rd_in && !seg_valid_out && wait_cnt == 2'h2;
        wait_cnt <= (seg_rd_in && !seg_valid_out) ? wait_cnt + 2'h1 : 2'h0;
        seg_data_out <= ~seg_data_out;
        if (seg_rd_in && wait_cnt == 2'h2) begin
            // Full address match, so a table that was not moved gets nothing
            seg_data_out <= (seg_addr_in == 32'h0000_0104) ? 32'h0002_0003
                : 32'h0;
        end
    end
    // Peripheral data tagged with its address, one cycle after strobe
    always @(posedge clk_in) begin
        sfr_data_out <= sfr_rd_in ? {24'h5a5a5a, sfr_addr_in} : ~sfr_data_out;
    end
endmodule

// ===== tb_top.sv
// Purpose: Walks every CPU mode through grant and deny cases.
// Assumes: Far side answers forwarded reads with its own address.
// Notes: Each access waits for waitrequest under a bounded loop.
`timescale 1ns/1ps
module tb_top;
    import sfr_check_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, exc;
    logic cp_src = 1'b0, cp_st = 1'b0, cp_dn = 1'b0, wreq, seg_rd, seg_vld;
    logic [7:0] addr = 8'h0, sfr_addr;
    logic [31:0] wdata = 32'h0, rdata, seg_addr, seg_dat, sfr_dat;
    logic [2:0] mode = MODE_SYSTEM;
    logic [5:0] seg = 6'h1;
    logic sfr_rd;
    logic sfr_wr;
    logic [31:0] sfr_wd, wd_seen = 32'h0;
    logic [3:0] sfr_be;
    logic [11:0] wr_seen = 12'h0;
    int error_cnt = 0, comparisons = 0, exc_cnt = 0;
    always #5 clk = ~clk;
    sfr_mode_access_checker i_dut (.core_clk_in(clk), .sys_rst_in(rst),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .cpu_mode_in(mode), .seg_index_in(seg), .copy_src_in(cp_src),
        .copy_start_in(cp_st), .copy_done_in(cp_dn), .seg_rd_out(seg_rd),
        .seg_addr_out(seg_addr), .seg_rd_valid_in(seg_vld),
        .seg_rdata_in(seg_dat), .sfr_rd_out(sfr_rd), .sfr_wr_out(sfr_wr),
        .sfr_addr_out(sfr_addr), .sfr_wdata_out(sfr_wd), .sfr_be_out(sfr_be),
        .sfr_rdata_in(sfr_dat), .exception_out(exc));
    far_side_model i_far (.clk_in(clk), .seg_rd_in(seg_rd),
        .seg_addr_in(seg_addr), .sfr_rd_in(sfr_rd), .sfr_addr_in(sfr_addr),
        .seg_valid_out(seg_vld), .seg_data_out(seg_dat),
        .sfr_data_out(sfr_dat));
    // Count exception pulses so each access can see its own
    always @(posedge clk) if (exc === 1'b1) exc_cnt <= exc_cnt + 1;
    // Remember the last forwarded write so leaks past a denial show up
    always @(posedge clk) begin
        if (sfr_wr === 1'b1) begin
            wr_seen <= {sfr_be, sfr_addr};
            wd_seen <= sfr_wd;
        end
    end
    function automatic logic [31:0] fw(input logic [7:0] a);
        return {24'h5a5a5a, a};
    endfunction
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    // One bus access; ok means granted, denied reads must return zero
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] e, input logic ok);
        int n;
        int e0;
        @(posedge clk);
        e0 = exc_cnt;
        n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 60);
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 60) begin
            error_cnt++;
            report_and_stop();
        end else begin
            if (!w) chk("readdata", ok ? e : 32'h0, rdata);
            chk("granted", {31'h0, ok}, {31'h0, exc_cnt == e0});
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        acc(0, 8'h18, 0, 32'h0, 1);
        acc(1, 8'h18, 32'h100, 0, 1);
        acc(0, 8'h18, 0, 32'h100, 1);
        acc(0, 8'h21, 0, 0, 0);
        acc(0, 8'h30, 0, 32'h0, 1);
        acc(0, 8'h10, 0, fw(8'h10), 1);
        acc(0, 8'h82, 0, fw(8'h82), 1);
        acc(1, 8'h81, 5, 0, 0);
        chk("sfr write", 32'h0, {20'h0, wr_seen});
        acc(1, 8'h88, 5, 0, 1);
        chk("sfr write", {20'h0, 12'hf88}, {20'h0, wr_seen});
        chk("sfr wdata", 32'h5, wd_seen);
        acc(0, 8'h88, 0, 0, 0);
        acc(0, 8'h60, 0, 0, 0);
        mode <= MODE_BOOT;
        acc(0, 8'h40, 0, 0, 0);
        acc(0, 8'h38, 0, fw(8'h38), 1);
        acc(0, 8'h18, 0, 0, 0);
        acc(0, 8'h10, 0, 0, 0);
        acc(0, 8'h00, 0, fw(8'h00), 1);
        mode <= MODE_TEST;
        acc(0, 8'h40, 0, fw(8'h40), 1);
        acc(1, 8'h10, 1, 0, 0);
        mode <= MODE_FIRMWARE;
        acc(0, 8'h31, 0, 32'h0, 1);
        acc(1, 8'h30, 32'h4, 0, 0);
        acc(0, 8'h3c, 0, fw(8'h3c), 1);
        acc(0, 8'h80, 0, fw(8'h80), 1);
        acc(0, 8'h82, 0, 0, 0);
        acc(0, 8'h20, 0, fw(8'h20), 1);
        acc(1, 8'h20, 1, 0, 0);
        chk("sfr write", {20'h0, 12'hf88}, {20'h0, wr_seen});
        mode <= MODE_SYSTEM;
        acc(0, 8'h30, 0, 32'h0, 1);
        acc(1, 8'h30, 32'h4, 0, 1);
        mode <= MODE_FIRMWARE;
        acc(0, 8'h82, 0, fw(8'h82), 1);
        mode <= MODE_USER;
        acc(0, 8'h81, 0, fw(8'h81), 1);
        acc(0, 8'h82, 0, 0, 0);
        acc(1, 8'h18, 1, 0, 0);
        acc(0, 8'h20, 0, fw(8'h20), 1);
        seg <= 6'h0;
        acc(0, 8'h81, 0, 0, 0);
        mode <= MODE_SYSTEM;
        cp_st <= 1'b1;
        @(posedge clk);
        cp_st <= 1'b0;
        mode <= MODE_USER;
        cp_src <= 1'b1;
        acc(0, 8'h18, 0, 32'h100, 1);
        cp_dn <= 1'b1;
        @(posedge clk);
        cp_dn <= 1'b0;
        acc(0, 8'h18, 0, 0, 0);
        report_and_stop();
    end
endmodule
